//--- qta_pkg.sv
// Constants shared by the Q-channel trim and aperture register bank.
package qta_pkg;

  // ==========================================================================
  // Register addresses, as sent in the serial frame.
  localparam logic [3:0]  QTA_ADDR_OFFSET    = 4'ha;
  localparam logic [3:0]  QTA_ADDR_FULLSCALE = 4'hb;
  localparam logic [3:0]  QTA_ADDR_COARSE    = 4'hc;

  // ==========================================================================
  // Reset values and the bits that hold storage.
  localparam logic [15:0] QTA_RST_OFFSET     = 16'h0000;
  localparam logic [15:0] QTA_RST_FULLSCALE  = 16'h4000;
  localparam logic [15:0] QTA_RST_COARSE     = 16'h0004;
  localparam logic [15:0] QTA_MASK_OFFSET    = 16'h1fff;
  localparam logic [15:0] QTA_MASK_FULLSCALE = 16'h7fff;
  localparam logic [15:0] QTA_MASK_COARSE    = 16'hfffc;

  // ==========================================================================
  // Field positions.
  localparam int          QTA_OFS_MAG_MSB    = 11;
  localparam int          QTA_OFS_POL_BIT    = 12;
  localparam int          QTA_FS_MAG_MSB     = 14;
  localparam int          QTA_CAM_LSB        = 4;
  localparam int          QTA_CAM_MSB        = 15;
  localparam int          QTA_STA_BIT        = 3;
  localparam int          QTA_DCC_BIT        = 2;

  // ==========================================================================
  // Largest coarse delay code before the delay saturates (825 ps).
  localparam logic [11:0] QTA_CAM_MAX_CODE   = 12'h97f;

  // ==========================================================================
  // Serial frame layout: read flag, three spare bits, address, data.
  localparam logic [4:0]  QTA_FRAME_BITS     = 5'h18;
  localparam logic [4:0]  QTA_HEADER_BITS    = 5'h08;
  localparam int          QTA_FRAME_RD_BIT   = 23;
  localparam int          QTA_FRAME_ADDR_LSB = 16;

  typedef enum logic [1:0] {QTA_IDLE, QTA_SHIFT, QTA_DONE} qta_ser_state_t;

endpackage

//--- qta_q_trim_regs.sv
// Q-channel offset, full-scale and coarse aperture register bank.
//
// Overview of operation
// - Offset magnitude bits 11:0 set Q offset.
// - Bit 12 picks offset sign, 1 negative.
// - Full-scale bits 14:0 span 800-1000 mV.
// - Coarse register fields; resets to 0004h.
// - Coarse delay saturates from code 2432 up.
// - Delay applies only while adjust select set.
// - Clearing correction bit disables duty stabiliser.
`timescale 1ns/1ps

module qta_q_trim_regs
  import qta_pkg::*;
#(
  parameter int MAG_W = 12,
  parameter int FS_W  = 15
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             sclk_in,
  input  wire logic             scs_n_in,
  input  wire logic             sdi_in,
  output logic                  sdo_out,
  output logic                  sdo_oe_out,
  output logic [MAG_W-1:0]      offset_magnitude_out,
  output logic                  offset_polarity_out,
  output logic [MAG_W:0]        signed_offset_out,
  output logic [FS_W-1:0]       fullscale_magnitude_out,
  output logic [11:0]           coarse_delay_magnitude_out,
  output logic [11:0]           coarse_delay_applied_out,
  output logic                  aperture_adjust_select_out,
  output logic                  duty_cycle_correct_en_out
);
  import qta_pkg::*;

  logic [15:0] q_offset_trim;
  logic [15:0] q_fullscale_trim;
  logic [15:0] aperture_delay_coarse;
  logic [15:0] next_q_offset_trim;
  logic [15:0] next_q_fullscale_trim;
  logic [15:0] next_aperture_delay_coarse;
  logic [11:0] next_coarse_applied;
  logic [MAG_W:0] next_signed_offset;
  logic [3:0]  rd_addr;
  logic [15:0] rd_data;
  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [15:0] wr_data;

  // ==========================================================================
  // Serial port.
  qta_serial_slave u_serial (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .sclk_in     (sclk_in),
    .scs_n_in    (scs_n_in),
    .sdi_in      (sdi_in),
    .sdo_out     (sdo_out),
    .sdo_oe_out  (sdo_oe_out),
    .rd_addr_out (rd_addr),
    .rd_data_in  (rd_data),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data)
  );

  // Clamps a coarse code to the point where the delay stops growing.
  function automatic logic [11:0] qta_clamp_cam(input logic [11:0] code);
    qta_clamp_cam = (code > QTA_CAM_MAX_CODE) ? QTA_CAM_MAX_CODE : code;
  endfunction

  // ==========================================================================
  // Register writes. Reserved bits hold no storage and read back as zero,
  // so a stray one written there has no effect.
  always_comb begin
    next_q_offset_trim         = q_offset_trim;
    next_q_fullscale_trim      = q_fullscale_trim;
    next_aperture_delay_coarse = aperture_delay_coarse;
    if (wr_en) begin
      unique case (wr_addr)
        QTA_ADDR_OFFSET:    next_q_offset_trim         = wr_data & QTA_MASK_OFFSET;
        QTA_ADDR_FULLSCALE: next_q_fullscale_trim      = wr_data & QTA_MASK_FULLSCALE;
        QTA_ADDR_COARSE:    next_aperture_delay_coarse = wr_data & QTA_MASK_COARSE;
        default: ;
      endcase
    end
  end

  // Read mux; addresses outside the bank read as zero.
  always_comb begin
    unique case (rd_addr)
      QTA_ADDR_OFFSET:    rd_data = q_offset_trim;
      QTA_ADDR_FULLSCALE: rd_data = q_fullscale_trim;
      QTA_ADDR_COARSE:    rd_data = aperture_delay_coarse;
      default:            rd_data = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Values handed to the analog trims. The applied delay and signed offset follow the
  // stored fields by one clock; the other trim outputs follow the register directly.
  always_comb begin
    if (aperture_delay_coarse[QTA_STA_BIT]) begin
      next_coarse_applied = qta_clamp_cam(aperture_delay_coarse[QTA_CAM_MSB:QTA_CAM_LSB]);
    end else begin
      next_coarse_applied = 12'h000;
    end
    if (q_offset_trim[QTA_OFS_POL_BIT]) begin
      next_signed_offset = (MAG_W+1)'(-{1'b0, q_offset_trim[QTA_OFS_MAG_MSB:0]});
    end else begin
      next_signed_offset = {1'b0, q_offset_trim[QTA_OFS_MAG_MSB:0]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q_offset_trim              <= QTA_RST_OFFSET;
      q_fullscale_trim           <= QTA_RST_FULLSCALE;
      aperture_delay_coarse      <= QTA_RST_COARSE;
      coarse_delay_applied_out   <= 12'h000;
      signed_offset_out          <= '0;
    end else begin
      q_offset_trim              <= next_q_offset_trim;
      q_fullscale_trim           <= next_q_fullscale_trim;
      aperture_delay_coarse      <= next_aperture_delay_coarse;
      coarse_delay_applied_out   <= next_coarse_applied;
      signed_offset_out          <= next_signed_offset;
    end
  end

  assign offset_magnitude_out       = q_offset_trim[QTA_OFS_MAG_MSB:0];
  assign offset_polarity_out        = q_offset_trim[QTA_OFS_POL_BIT];
  assign fullscale_magnitude_out    = q_fullscale_trim[QTA_FS_MAG_MSB:0];
  assign coarse_delay_magnitude_out = aperture_delay_coarse[QTA_CAM_MSB:QTA_CAM_LSB];
  assign aperture_adjust_select_out = aperture_delay_coarse[QTA_STA_BIT];
  assign duty_cycle_correct_en_out  = aperture_delay_coarse[QTA_DCC_BIT];

  // ==========================================================================
  // Assertions.
  default clocking qta_cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  reset_values_a: assert property ($rose(nrst_in) |->
      aperture_delay_coarse == 16'h0004 && q_fullscale_trim == 16'h4000 && q_offset_trim == 16'h0000)
    else $error("register bank left reset with wrong values");
  offset_write_a: assert property (wr_en && wr_addr == QTA_ADDR_OFFSET |=>
      offset_magnitude_out == $past(wr_data[11:0]) && q_offset_trim[15:13] == 3'h0)
    else $error("offset write not stored");
  offset_sign_a: assert property (offset_polarity_out |=>
      signed_offset_out == (MAG_W+1)'(-{1'b0, $past(offset_magnitude_out)}))
    else $error("negative offset wrong");
  fullscale_write_a: assert property (wr_en && wr_addr == QTA_ADDR_FULLSCALE |=>
      fullscale_magnitude_out == $past(wr_data[14:0]) && !q_fullscale_trim[15])
    else $error("full-scale write not stored");
  coarse_fields_a: assert property (wr_en && wr_addr == QTA_ADDR_COARSE |=>
      aperture_delay_coarse[1:0] == 2'h0 && duty_cycle_correct_en_out == $past(wr_data[2]))
    else $error("coarse register fields wrong");
  delay_saturate_a: assert property (aperture_adjust_select_out && coarse_delay_magnitude_out >= 12'h980 |=>
      coarse_delay_applied_out == 12'h97f)
    else $error("coarse delay did not saturate");
  delay_gated_a: assert property (!aperture_adjust_select_out |=> coarse_delay_applied_out == 12'h000)
    else $error("delay applied while adjust off");
  dcc_off_a: assert property (wr_en && wr_addr == QTA_ADDR_COARSE && !wr_data[2] |=>
      (!duty_cycle_correct_en_out) [*2])
    else $error("duty-cycle correction not disabled");
  unmapped_write_a: assert property (wr_en && wr_addr != QTA_ADDR_OFFSET && wr_addr != QTA_ADDR_FULLSCALE
      && wr_addr != QTA_ADDR_COARSE |=> $stable(q_offset_trim)
      && $stable(q_fullscale_trim) && $stable(aperture_delay_coarse))
    else $error("unmapped write changed a register");

  // ==========================================================================
  // Field, isolation and reset checks.
  offset_plus_a: assert property (!offset_polarity_out |=>
      signed_offset_out == {1'b0, $past(offset_magnitude_out)})
    else $error("positive offset wrong");
  polarity_write_a: assert property (wr_en && wr_addr == QTA_ADDR_OFFSET |=>
      offset_polarity_out == $past(wr_data[12]))
    else $error("offset sign not stored");
  coarse_code_a: assert property (wr_en && wr_addr == QTA_ADDR_COARSE |=>
      coarse_delay_magnitude_out == $past(wr_data[15:4]))
    else $error("coarse code not stored");
  select_write_a: assert property (wr_en && wr_addr == QTA_ADDR_COARSE |=>
      aperture_adjust_select_out == $past(wr_data[3]))
    else $error("adjust select not stored");
  delay_linear_a: assert property (aperture_adjust_select_out && coarse_delay_magnitude_out <= 12'h97f |=>
      coarse_delay_applied_out == $past(coarse_delay_magnitude_out))
    else $error("coarse delay not passed through");
  applied_bound_a: assert property (coarse_delay_applied_out <= 12'h97f)
    else $error("applied delay above the maximum code");
  derived_reset_a: assert property ($rose(nrst_in) |->
      coarse_delay_applied_out == 12'h000 && signed_offset_out == '0)
    else $error("derived outputs left reset nonzero");
  dcc_reset_a: assert property ($rose(nrst_in) |->
      duty_cycle_correct_en_out && !aperture_adjust_select_out)
    else $error("correction or select wrong after reset");
  regs_hold_a: assert property (!wr_en |=> $stable(q_offset_trim) && $stable(q_fullscale_trim)
      && $stable(aperture_delay_coarse))
    else $error("register changed without a write");
  reserved_zero_a: assert property (q_offset_trim[15:13] == 3'h0 && !q_fullscale_trim[15]
      && aperture_delay_coarse[1:0] == 2'h0)
    else $error("reserved bit holds a one");
  offset_isolate_a: assert property (wr_en && wr_addr == QTA_ADDR_OFFSET |=>
      $stable(q_fullscale_trim) && $stable(aperture_delay_coarse))
    else $error("offset write disturbed another register");
  fs_isolate_a: assert property (wr_en && wr_addr == QTA_ADDR_FULLSCALE |=>
      $stable(q_offset_trim) && $stable(aperture_delay_coarse))
    else $error("full-scale write disturbed another register");
  coarse_isolate_a: assert property (wr_en && wr_addr == QTA_ADDR_COARSE |=>
      $stable(q_offset_trim) && $stable(q_fullscale_trim))
    else $error("coarse write disturbed another register");

  cov_neg_offset: cover property (wr_en && wr_addr == QTA_ADDR_OFFSET && wr_data[12]);
  cov_saturate: cover property (coarse_delay_applied_out == 12'h97f);
  cov_dcc_off: cover property ($fell(duty_cycle_correct_en_out));
  cov_readback: cover property ($rose(sdo_oe_out));
  cov_linear: cover property (aperture_adjust_select_out && coarse_delay_applied_out == 12'h600);

endmodule // qta_q_trim_regs

//--- qta_serial_slave.sv
// Serial configuration port that turns frames into register reads and writes.
`timescale 1ns/1ps

module qta_serial_slave
  import qta_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        sclk_in,
  input  wire logic        scs_n_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  output logic [3:0]       rd_addr_out,
  input  wire logic [15:0] rd_data_in,
  output logic             wr_en_out,
  output logic [3:0]       wr_addr_out,
  output logic [15:0]      wr_data_out
);
  import qta_pkg::*;

  qta_ser_state_t state;
  qta_ser_state_t next_state;
  logic           sclk_q;
  logic [4:0]     cnt;
  logic [4:0]     next_cnt;
  logic [23:0]    rx_sh;
  logic [23:0]    next_rx_sh;
  logic [15:0]    tx_sh;
  logic [15:0]    next_tx_sh;
  logic           next_sdo_oe;
  logic           next_wr_en;
  logic [3:0]     next_wr_addr;
  logic [15:0]    next_wr_data;
  logic           sclk_rise;
  logic           sclk_fall;

  assign sclk_rise   = sclk_in & ~sclk_q;
  assign sclk_fall   = ~sclk_in & sclk_q;
  assign sdo_out     = tx_sh[15];
  assign rd_addr_out = rx_sh[3:0];

  // ==========================================================================
  // Frame decoding: bits are taken on rising serial clock edges, read data
  // leaves on falling edges once the eight header bits are in.
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_rx_sh    = rx_sh;
    next_tx_sh    = tx_sh;
    next_sdo_oe   = sdo_oe_out;
    next_wr_en    = 1'b0;
    next_wr_addr  = wr_addr_out;
    next_wr_data  = wr_data_out;
    if (scs_n_in) begin
      next_state  = QTA_IDLE;
      next_cnt    = 5'h00;
      next_tx_sh  = 16'h0000;
      next_sdo_oe = 1'b0;
    end else begin
      unique case (state)
        QTA_IDLE, QTA_SHIFT: begin
          next_state = QTA_SHIFT;
          if (sclk_rise) begin
            next_rx_sh = {rx_sh[22:0], sdi_in};
            next_cnt   = cnt + 5'h01;
            if (next_cnt == QTA_FRAME_BITS) begin
              next_state = QTA_DONE;
              if (!next_rx_sh[QTA_FRAME_RD_BIT]) begin
                next_wr_en   = 1'b1;
                next_wr_addr = next_rx_sh[QTA_FRAME_ADDR_LSB +: 4];
                next_wr_data = next_rx_sh[15:0];
              end
            end
          end else if (sclk_fall && cnt == QTA_HEADER_BITS && rx_sh[7]) begin
            next_tx_sh  = rd_data_in;
            next_sdo_oe = 1'b1;
          end else if (sclk_fall && cnt > QTA_HEADER_BITS) begin
            next_tx_sh = {tx_sh[14:0], 1'b0};
          end
        end
        QTA_DONE: begin
          next_state = QTA_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state       <= QTA_IDLE;
      sclk_q      <= 1'b0;
      cnt         <= 5'h00;
      rx_sh       <= 24'h000000;
      tx_sh       <= 16'h0000;
      sdo_oe_out  <= 1'b0;
      wr_en_out   <= 1'b0;
      wr_addr_out <= 4'h0;
      wr_data_out <= 16'h0000;
    end else begin
      state       <= next_state;
      sclk_q      <= sclk_in;
      cnt         <= next_cnt;
      rx_sh       <= next_rx_sh;
      tx_sh       <= next_tx_sh;
      sdo_oe_out  <= next_sdo_oe;
      wr_en_out   <= next_wr_en;
      wr_addr_out <= next_wr_addr;
      wr_data_out <= next_wr_data;
    end
  end

endmodule // qta_serial_slave

//--- tb_top.sv
// Self-checking testbench for the Q-channel trim and aperture register bank.
`timescale 1ns/1ps

module tb_top;
  import qta_pkg::*;

  logic        clk_in;
  logic        nrst_in;
  logic        sclk_in;
  logic        scs_n_in;
  logic        sdi_in;
  logic        sdo_out;
  logic        sdo_oe_out;
  logic [11:0] ofs_mag;
  logic        ofs_pol;
  logic [12:0] ofs_signed;
  logic [14:0] fs_mag;
  logic [11:0] cam_raw;
  logic [11:0] cam_applied;
  logic        adj_sel;
  logic        dcc_en;
  int          bad_count;
  int          compares;

  qta_q_trim_regs #(.MAG_W(12), .FS_W(15)) i_dut (
    .clk_in                     (clk_in),
    .nrst_in                    (nrst_in),
    .sclk_in                    (sclk_in),
    .scs_n_in                   (scs_n_in),
    .sdi_in                     (sdi_in),
    .sdo_out                    (sdo_out),
    .sdo_oe_out                 (sdo_oe_out),
    .offset_magnitude_out       (ofs_mag),
    .offset_polarity_out        (ofs_pol),
    .signed_offset_out          (ofs_signed),
    .fullscale_magnitude_out    (fs_mag),
    .coarse_delay_magnitude_out (cam_raw),
    .coarse_delay_applied_out   (cam_applied),
    .aperture_adjust_select_out (adj_sel),
    .duty_cycle_correct_en_out  (dcc_en)
  );

  // ==========================================================================
  // Clock, common tasks and the closing report.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic clks(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Sends one frame of nbits bits; read data is gathered on rises 9..24.
  task automatic frame(input logic rd, input logic [3:0] addr, input logic [15:0] data,
                       input int nbits, output logic [15:0] rdata);
    logic [23:0] f;
    f = {rd, 3'h0, addr, data};
    rdata = 16'h0000;
    scs_n_in = 1'b0;
    clks(1);
    for (int i = 0; i < nbits; i++) begin
      sdi_in = f[23-i];
      sclk_in = 1'b1;
      clks(3);
      if (i >= 8)
        rdata = {rdata[14:0], sdo_out};
      if (i >= 8 && rd)
        chk({15'h0000, sdo_oe_out}, 16'h0001, "sdo enable in read");
      sclk_in = 1'b0;
      sdi_in = ~sdi_in;
      clks(3);
    end
    scs_n_in = 1'b1;
    clks(4);
  endtask

  task automatic wr(input logic [3:0] addr, input logic [15:0] data);
    logic [15:0] unused;
    frame(1'b0, addr, data, 24, unused);
  endtask

  task automatic rd_chk(input logic [3:0] addr, input logic [15:0] exp);
    logic [15:0] got;
    frame(1'b1, addr, 16'h0000, 24, got);
    chk(got, exp, "register read");
    chk({15'h0000, sdo_oe_out}, 16'h0000, "sdo enable after frame");
    chk({15'h0000, sdo_out}, 16'h0000, "sdo idle after frame");
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic test_reset();
    chk({4'h0, ofs_mag}, 16'h0000, "offset after reset");
    chk({15'h0000, ofs_pol}, 16'h0000, "polarity after reset");
    chk({1'b0, fs_mag}, 16'h4000, "fullscale after reset");
    chk({cam_raw, adj_sel, dcc_en, 2'h0}, 16'h0004, "coarse reset");
    chk({4'h0, cam_applied}, 16'h0000, "applied after reset");
    rd_chk(QTA_ADDR_OFFSET, QTA_RST_OFFSET);
    rd_chk(QTA_ADDR_FULLSCALE, QTA_RST_FULLSCALE);
    rd_chk(QTA_ADDR_COARSE, QTA_RST_COARSE);
    $display("test reset done");
  endtask

  task automatic test_offset();
    wr(QTA_ADDR_OFFSET, 16'h1005);
    chk({4'h0, ofs_mag}, 16'h0005, "offset magnitude");
    chk({15'h0000, ofs_pol}, 16'h0001, "negative polarity");
    chk({3'h0, ofs_signed}, 16'h1ffb, "signed offset negative");
    wr(QTA_ADDR_OFFSET, 16'h0800);
    chk({3'h0, ofs_signed}, 16'h0800, "signed offset positive");
    wr(QTA_ADDR_OFFSET, 16'hffff);
    chk({4'h0, ofs_mag}, 16'h0fff, "offset all ones");
    rd_chk(QTA_ADDR_OFFSET, 16'h1fff);
    $display("test offset done");
  endtask

  task automatic test_fullscale();
    wr(QTA_ADDR_FULLSCALE, 16'h4001);
    chk({1'b0, fs_mag}, 16'h4001, "fullscale low step");
    wr(QTA_ADDR_FULLSCALE, 16'hffff);
    chk({1'b0, fs_mag}, 16'h7fff, "fullscale all ones");
    rd_chk(QTA_ADDR_FULLSCALE, 16'h7fff);
    $display("test fullscale done");
  endtask

  task automatic test_coarse();
    logic [11:0] codes [4] = '{12'h97f, 12'h980, 12'hfff, 12'h001};
    logic [11:0] caps  [4] = '{12'h97f, 12'h97f, 12'h97f, 12'h001};
    for (int k = 0; k < 4; k++) begin
      wr(QTA_ADDR_COARSE, {codes[k], 4'h8});
      chk({4'h0, cam_raw}, {4'h0, codes[k]}, "coarse raw code");
      chk({4'h0, cam_applied}, {4'h0, caps[k]}, "coarse applied");
      chk({15'h0000, dcc_en}, 16'h0000, "duty correction off");
    end
    wr(QTA_ADDR_COARSE, 16'h6008);
    chk({4'h0, cam_applied}, 16'h0600, "coarse applied mid range");
    wr(QTA_ADDR_COARSE, 16'h1237);
    chk({4'h0, cam_applied}, 16'h0000, "select off gives no delay");
    chk({14'h0000, adj_sel, dcc_en}, 16'h0001, "select and dcc bits");
    wr(QTA_ADDR_COARSE, 16'hffff);
    rd_chk(QTA_ADDR_COARSE, 16'hfffc);
    $display("test coarse done");
  endtask

  task automatic test_refused();
    logic [15:0] unused;
    wr(4'h5, 16'h1234);
    rd_chk(4'h5, 16'h0000);
    frame(1'b0, QTA_ADDR_FULLSCALE, 16'h0123, 20, unused);
    rd_chk(QTA_ADDR_FULLSCALE, 16'h7fff);
    nrst_in = 1'b0;
    clks(2);
    nrst_in = 1'b1;
    clks(1);
    rd_chk(QTA_ADDR_COARSE, QTA_RST_COARSE);
    $display("test refused done");
  endtask

  // ==========================================================================
  // Main sequence and hang guard.
  initial begin
    bad_count = 0;
    compares = 0;
    nrst_in = 1'b0;
    sclk_in = 1'b0;
    scs_n_in = 1'b1;
    sdi_in = 1'b0;
    clks(4);
    nrst_in = 1'b1;
    clks(1);
    test_reset();
    test_offset();
    test_fullscale();
    test_coarse();
    test_refused();
    final_report();
  end

  initial begin
    #4000000;
    bad_count++;
    $display("BAD %0t run did not finish in time", $time);
    final_report();
  end

endmodule // tb_top
